//--- bcrc_pkg.sv
// Package of the coprocessor byte CRC unit: opcodes, polynomials, widths.
// Assumes the core pipeline decodes instruction words and supplies operands.
package bcrc_pkg;

   // ==========================================================
   // Widths
   localparam int WORD_W = 16;
   localparam int CRC_W  = 32;

   // ==========================================================
   // First opcode word encodings
   localparam logic [15:0] OP_CRC8_HI   = 16'he2cc;
   localparam logic [15:0] OP_CRC8_LO   = 16'he2cb;
   localparam logic [15:0] OP_CRC16A_HI = 16'he2cf;
   localparam logic [15:0] OP_CRC16_LO  = 16'he2ce;
   localparam logic [15:0] OP_CRC16B_HI = 16'he2ef;
   localparam logic [15:0] OP_CRC32_HI  = 16'he2c2;
   localparam logic [15:0] OP_CRC32_LO  = 16'he2c1;
   localparam logic [15:0] OP_CLEAR     = 16'he524;
   localparam logic [15:0] OP_STORE     = 16'he206;
   localparam logic [15:0] OP_LOAD      = 16'he3f6;

   // Upper byte of the second opcode word
   localparam logic [7:0]  SEL_POLY_A   = 8'h00;
   localparam logic [7:0]  SEL_POLY_B   = 8'h10;

   // ==========================================================
   // Generator polynomials
   localparam logic [7:0]  POLY8   = 8'h07;
   localparam logic [15:0] POLY16A = 16'h8005;
   localparam logic [15:0] POLY16B = 16'h1021;
   localparam logic [31:0] POLY32  = 32'h04c11db7;

   localparam logic [31:0] CRC_RESET = 32'h00000000;

   // ==========================================================
   // CRC width selector
   typedef enum logic [1:0] {
      BCRC_W8  = 2'h0,
      BCRC_W16 = 2'h1,
      BCRC_W32 = 2'h2
   } bcrc_width_t;

endpackage : bcrc_pkg

//--- bcrc_fold.sv
// Combinational byte fold for CRC8, CRC16 and CRC32, MSB first.
// Assumes the caller selects width and polynomial; no reflection, no final xor.
`timescale 1ns/1ps
module bcrc_fold
(
   input  wire logic [31:0]       seed_i,
   input  wire logic [7:0]        data_i,
   input  wire logic [31:0]       poly_i,
   input  wire logic [1:0]        width_i,
   output logic      [31:0]       crc_o
);

   // ==========================================================
   // Eight shift steps on a 32-bit left aligned register
   logic [31:0] stage [0:8];
   logic [31:0] poly_al;
   logic [31:0] seed_al;

   always_comb
   begin
      case (width_i)
         2'h0:
         begin
            poly_al = {poly_i[7:0], 24'h000000};
            seed_al = {seed_i[7:0] ^ data_i, 24'h000000};
         end
         2'h1:
         begin
            poly_al = {poly_i[15:0], 16'h0000};
            seed_al = {seed_i[15:8] ^ data_i, seed_i[7:0], 16'h0000};
         end
         default:
         begin
            poly_al = poly_i;
            seed_al = {seed_i[31:24] ^ data_i, seed_i[23:0]};
         end
      endcase
   end

   assign stage[0] = seed_al;

   genvar g;
   generate
      for (g = 0; g < 8; g++)
      begin : g_step
         assign stage[g+1] = stage[g][31] ? ({stage[g][30:0], 1'b0} ^ poly_al)
                                          : {stage[g][30:0], 1'b0};
      end
   endgenerate

   // Narrow results drop back to the low bits, upper bits cleared
   always_comb
   begin
      case (width_i)
         2'h0:    crc_o = {24'h000000, stage[8][31:24]};
         2'h1:    crc_o = {16'h0000, stage[8][31:16]};
         default: crc_o = stage[8];
      endcase
   end

endmodule : bcrc_fold

//--- bcrc_unit.sv
// Byte CRC datapath of the vector coprocessor: decode, fold, result register.
// Assumes the core presents both opcode words and the memory operand in the
// same cycle as instr_valid_i, and writes store data itself.
//
// Summary of operation
// - CRC8 uses generator polynomial 0x07
// - CRC8 high byte takes operand bits 15:8
// - CRC8 low byte takes operand bits 7:0
// - First CRC16 pair uses polynomial 0x8005
// - Second CRC16 pair uses polynomial 0x1021
// - CRC16 high byte ops use bits 15:8
// - CRC16 low byte ops use bits 7:0
// - CRC32 low byte: bits 7:0, 0x04C11DB7
// - CRC32 high byte: same polynomial, bits 15:8
// - Result register is seed and destination
// - CRC operations change no status flags
// - Each operation completes in one cycle
// - Decode CRC8 high and low opcodes
// - Decode first polynomial CRC16 opcodes, upper 00
// - Decode second polynomial CRC16, upper byte 10
// - Decode CRC32 high and low opcodes
// - One 16-bit operand supplied per operation
// - Clear zeroes result in one cycle
// - Store drives result on write path
// - Load overwrites result from memory
`timescale 1ns/1ps
module bcrc_unit
(
   input  wire logic        mclk_i,
   input  wire logic        reset_i,
   input  wire logic        instr_valid_i,
   input  wire logic [15:0] first_opcode_word_i,
   input  wire logic [15:0] second_opcode_word_i,
   input  wire logic [15:0] half_word_memory_operand_i,
   input  wire logic [31:0] load_data_i,
   output logic      [7:0]  mem_addr_o,
   output logic             crc_op_o,
   output logic      [31:0] store_data_o,
   output logic             store_valid_o,
   output logic      [31:0] crc_result_register_o,
   output logic             status_write_o
);

   // ==========================================================
   // Decode
   logic              crc8_high_byte_op;
   logic              crc8_low_byte_op;
   logic              crc16_poly_a_high_byte_op;
   logic              crc16_poly_a_low_byte_op;
   logic              crc16_poly_b_high_byte_op;
   logic              crc16_poly_b_low_byte_op;
   logic              crc32_high_byte_op;
   logic              crc32_low_byte_op;
   logic              crc_result_clear_op;
   logic              wide_store_op;
   logic              wide_move_op;
   logic              is_crc;
   logic              hi_sel;
   logic [7:0]        upper_sel;
   logic [7:0]        data_byte;
   logic [31:0]       poly_sel;
   bcrc_pkg::bcrc_width_t width_sel;
   logic [31:0]       next_crc;
   logic [31:0]       crc_result_register;

   assign upper_sel = second_opcode_word_i[15:8];

   assign crc8_high_byte_op = instr_valid_i
                              && first_opcode_word_i == bcrc_pkg::OP_CRC8_HI;
   assign crc8_low_byte_op  = instr_valid_i
                              && first_opcode_word_i == bcrc_pkg::OP_CRC8_LO;
   assign crc16_poly_a_high_byte_op = instr_valid_i
                              && first_opcode_word_i == bcrc_pkg::OP_CRC16A_HI
                              && upper_sel == bcrc_pkg::SEL_POLY_A;
   assign crc16_poly_a_low_byte_op  = instr_valid_i
                              && first_opcode_word_i == bcrc_pkg::OP_CRC16_LO
                              && upper_sel == bcrc_pkg::SEL_POLY_A;
   // Second pair is told apart from the first by the selector byte
   assign crc16_poly_b_high_byte_op = instr_valid_i
                              && first_opcode_word_i == bcrc_pkg::OP_CRC16B_HI
                              && upper_sel == bcrc_pkg::SEL_POLY_B;
   assign crc16_poly_b_low_byte_op  = instr_valid_i
                              && first_opcode_word_i == bcrc_pkg::OP_CRC16_LO
                              && upper_sel == bcrc_pkg::SEL_POLY_B;
   assign crc32_high_byte_op = instr_valid_i
                              && first_opcode_word_i == bcrc_pkg::OP_CRC32_HI;
   assign crc32_low_byte_op  = instr_valid_i
                              && first_opcode_word_i == bcrc_pkg::OP_CRC32_LO;
   assign crc_result_clear_op = instr_valid_i
                              && first_opcode_word_i == bcrc_pkg::OP_CLEAR;
   // Store and load share the second word layout: upper byte zero
   assign wide_store_op = instr_valid_i && upper_sel == 8'h00
                          && first_opcode_word_i == bcrc_pkg::OP_STORE;
   assign wide_move_op  = instr_valid_i && upper_sel == 8'h00
                          && first_opcode_word_i == bcrc_pkg::OP_LOAD;

   assign hi_sel = crc8_high_byte_op || crc16_poly_a_high_byte_op
                   || crc16_poly_b_high_byte_op || crc32_high_byte_op;
   assign is_crc = hi_sel || crc8_low_byte_op || crc16_poly_a_low_byte_op
                   || crc16_poly_b_low_byte_op || crc32_low_byte_op;

   // ==========================================================
   // Operand byte and polynomial selection
   assign data_byte = hi_sel ? half_word_memory_operand_i[15:8]
                             : half_word_memory_operand_i[7:0];

   always_comb
   begin
      if (crc8_high_byte_op || crc8_low_byte_op)
      begin
         poly_sel  = {24'h000000, bcrc_pkg::POLY8};
         width_sel = bcrc_pkg::BCRC_W8;
      end
      else if (crc16_poly_a_high_byte_op || crc16_poly_a_low_byte_op)
      begin
         poly_sel  = {16'h0000, bcrc_pkg::POLY16A};
         width_sel = bcrc_pkg::BCRC_W16;
      end
      else if (crc16_poly_b_high_byte_op || crc16_poly_b_low_byte_op)
      begin
         poly_sel  = {16'h0000, bcrc_pkg::POLY16B};
         width_sel = bcrc_pkg::BCRC_W16;
      end
      else
      begin
         poly_sel  = bcrc_pkg::POLY32;
         width_sel = bcrc_pkg::BCRC_W32;
      end
   end

   bcrc_fold u_fold
   (
      .seed_i  (crc_result_register),
      .data_i  (data_byte),
      .poly_i  (poly_sel),
      .width_i (width_sel),
      .crc_o   (next_crc)
   );

   // ==========================================================
   // Result register
   always_ff @(posedge mclk_i)
   begin
      if (reset_i)
         crc_result_register <= bcrc_pkg::CRC_RESET;
      else if (crc_result_clear_op)
         crc_result_register <= bcrc_pkg::CRC_RESET;
      else if (wide_move_op)
         crc_result_register <= load_data_i;
      else if (is_crc)
         crc_result_register <= next_crc;
   end

   // ==========================================================
   // Store path, registered one cycle after the store is issued
   always_ff @(posedge mclk_i)
   begin
      if (reset_i)
      begin
         store_data_o  <= bcrc_pkg::CRC_RESET;
         store_valid_o <= 1'b0;
      end
      else
      begin
         store_valid_o <= wide_store_op;
         if (wide_store_op)
            store_data_o <= crc_result_register;
      end
   end

   // Operand address field, handed back so the core fetches the word
   assign mem_addr_o            = second_opcode_word_i[7:0];
   assign crc_op_o              = is_crc;
   assign crc_result_register_o = crc_result_register;
   // None of these operations ever writes coprocessor status
   assign status_write_o        = 1'b0;

   // ==========================================================
   // Checks
   // Rising edge only, all held off while reset is high
   logic              crc16_any_op;
   logic              lo_byte_op;

   assign crc16_any_op = crc16_poly_a_high_byte_op || crc16_poly_a_low_byte_op
                         || crc16_poly_b_high_byte_op || crc16_poly_b_low_byte_op;
   assign lo_byte_op   = crc8_low_byte_op || crc16_poly_a_low_byte_op
                         || crc16_poly_b_low_byte_op || crc32_low_byte_op;

   chk_crc8_hi_fold: assert property (
      @(posedge mclk_i) disable iff (reset_i)
      crc8_high_byte_op |=> crc_result_register[31:8] == 24'h000000)
      else $error("crc8 left upper bits set");

   chk_crc8_lo_fold: assert property (
      @(posedge mclk_i) disable iff (reset_i)
      crc8_low_byte_op |=> crc_result_register[31:8] == 24'h000000)
      else $error("crc8 low byte left upper bits set");

   chk_crc16_fold: assert property (
      @(posedge mclk_i) disable iff (reset_i)
      crc16_any_op |=> crc_result_register[31:16] == 16'h0000)
      else $error("crc16 left upper bits set");

   chk_clear_zero: assert property (
      @(posedge mclk_i) disable iff (reset_i)
      crc_result_clear_op |=> crc_result_register == 32'h00000000)
      else $error("clear did not zero result");

   chk_load_value: assert property (
      @(posedge mclk_i) disable iff (reset_i)
      wide_move_op |=> crc_result_register == $past(load_data_i))
      else $error("load value not taken");

   chk_store_value: assert property (
      @(posedge mclk_i) disable iff (reset_i)
      wide_store_op |=> store_valid_o && store_data_o == $past(crc_result_register))
      else $error("store data wrong");

   chk_store_origin: assert property (
      @(posedge mclk_i) disable iff (reset_i)
      store_valid_o |-> $past(wide_store_op))
      else $error("store pulse without a store");

   // Store data stays put between stores, so a slow core can still take it
   chk_store_data_hold: assert property (
      @(posedge mclk_i) disable iff (reset_i)
      !wide_store_op |=> $stable(store_data_o))
      else $error("store data moved without a store");

   // Known answers: a zero seed and a single 01 byte leave the polynomial
   chk_crc8_zero_seed: assert property (
      @(posedge mclk_i) disable iff (reset_i)
      crc8_low_byte_op && crc_result_register == 32'h00000000
      && half_word_memory_operand_i[7:0] == 8'h01
      |=> crc_result_register == 32'h00000007)
      else $error("crc8 polynomial wrong");

   chk_crc8_hi_poly: assert property (
      @(posedge mclk_i) disable iff (reset_i)
      crc8_high_byte_op && crc_result_register == 32'h00000000
      && half_word_memory_operand_i[15:8] == 8'h01
      |=> crc_result_register == 32'h00000007)
      else $error("crc8 high byte wrong");

   chk_crc16a_poly: assert property (
      @(posedge mclk_i) disable iff (reset_i)
      crc16_poly_a_high_byte_op && crc_result_register == 32'h00000000
      && half_word_memory_operand_i[15:8] == 8'h01
      |=> crc_result_register == 32'h00008005)
      else $error("crc16 poly a wrong");

   chk_crc16a_lo_poly: assert property (
      @(posedge mclk_i) disable iff (reset_i)
      crc16_poly_a_low_byte_op && crc_result_register == 32'h00000000
      && half_word_memory_operand_i[7:0] == 8'h01
      |=> crc_result_register == 32'h00008005)
      else $error("crc16 poly a low byte wrong");

   chk_crc16b_poly: assert property (
      @(posedge mclk_i) disable iff (reset_i)
      crc16_poly_b_low_byte_op && crc_result_register == 32'h00000000
      && half_word_memory_operand_i[7:0] == 8'h01
      |=> crc_result_register == 32'h00001021)
      else $error("crc16 poly b wrong");

   chk_crc16b_hi_poly: assert property (
      @(posedge mclk_i) disable iff (reset_i)
      crc16_poly_b_high_byte_op && crc_result_register == 32'h00000000
      && half_word_memory_operand_i[15:8] == 8'h01
      |=> crc_result_register == 32'h00001021)
      else $error("crc16 poly b high byte wrong");

   chk_crc32_poly: assert property (
      @(posedge mclk_i) disable iff (reset_i)
      crc32_high_byte_op && crc_result_register == 32'h00000000
      && half_word_memory_operand_i[15:8] == 8'h01
      |=> crc_result_register == 32'h04c11db7)
      else $error("crc32 polynomial wrong");

   chk_crc32_lo_poly: assert property (
      @(posedge mclk_i) disable iff (reset_i)
      crc32_low_byte_op && crc_result_register == 32'h00000000
      && half_word_memory_operand_i[7:0] == 8'h01
      |=> crc_result_register == 32'h04c11db7)
      else $error("crc32 low byte wrong");

   // Zero seed and zero selected byte give zero, whatever the other byte
   chk_hi_skips_lo: assert property (
      @(posedge mclk_i) disable iff (reset_i)
      hi_sel && crc_result_register == 32'h00000000
      && half_word_memory_operand_i[15:8] == 8'h00
      |=> crc_result_register == 32'h00000000)
      else $error("high byte op used low byte");

   chk_lo_skips_hi: assert property (
      @(posedge mclk_i) disable iff (reset_i)
      lo_byte_op && crc_result_register == 32'h00000000
      && half_word_memory_operand_i[7:0] == 8'h00
      |=> crc_result_register == 32'h00000000)
      else $error("low byte op used high byte");

   chk_idle_hold: assert property (
      @(posedge mclk_i) disable iff (reset_i)
      !instr_valid_i |=> $stable(crc_result_register))
      else $error("result changed while idle");

   // Unknown codes and stores leave the result alone
   chk_refused_hold: assert property (
      @(posedge mclk_i) disable iff (reset_i)
      instr_valid_i && !is_crc && !crc_result_clear_op && !wide_move_op
      |=> $stable(crc_result_register))
      else $error("refused op changed result");

   chk_no_status: assert property (
      @(posedge mclk_i) disable iff (reset_i)
      is_crc |-> !status_write_o)
      else $error("status written by crc op");

   chk_crc_flag: assert property (
      @(posedge mclk_i) disable iff (reset_i)
      crc_op_o |-> instr_valid_i)
      else $error("crc op flagged without an instruction");

   // ==========================================================
   // Main scenarios
   cov_clear_crc8: cover property
      (@(posedge mclk_i) crc_result_clear_op ##1 crc8_high_byte_op);
   cov_crc16b_lo: cover property
      (@(posedge mclk_i) crc16_poly_b_low_byte_op);
   cov_chain_32_16: cover property
      (@(posedge mclk_i) crc32_high_byte_op ##1 crc16_poly_b_high_byte_op);
   cov_load_crc32: cover property
      (@(posedge mclk_i) wide_move_op ##1 crc32_high_byte_op);
   cov_load_store: cover property
      (@(posedge mclk_i) wide_move_op ##1 wide_store_op);

endmodule : bcrc_unit

//--- bcrc_core_model.sv
// Model of the host core pipeline side: data memory feeding operands and taking stores.
// Assumes the unit presents the memory field on mem_addr and pulses store_valid.
`timescale 1ns/1ps
module bcrc_core_model
(
   input  wire logic        mclk_i,
   input  wire logic [7:0]  mem_addr_i,
   input  wire logic [31:0] store_data_i,
   input  wire logic        store_valid_i,
   output logic      [15:0] operand_o,
   output logic      [31:0] load_data_o
);
   logic [15:0] mem [256];
   logic [7:0]  addr_q;

   // ==========================================================
   // Read path
   initial
   begin
      for (int i = 0; i < 256; i++) mem[i] = 16'h5a5a ^ 16'(i);
   end
   assign operand_o   = mem[mem_addr_i];
   assign load_data_o = {mem[mem_addr_i + 8'h01], mem[mem_addr_i]};

   // ==========================================================
   // Write path; the pulse comes a cycle late, so keep the issue address
   // Plain always: the bench preloads this memory too
   always @(posedge mclk_i)
   begin
      addr_q <= mem_addr_i;
      if (store_valid_i)
      begin
         mem[addr_q]         <= store_data_i[15:0];
         mem[addr_q + 8'h01] <= store_data_i[31:16];
      end
   end
endmodule : bcrc_core_model

//--- bcrc_unit_bench.sv
// Self-checking bench of the byte CRC unit with a core and memory model.
// Assumes one-cycle ops taken at the rising edge, inputs driven at the falling edge.
`timescale 1ns/1ps
module bcrc_unit_bench;
   logic        mclk_i = 1'b0;
   logic        reset_i = 1'b1;
   logic        instr_valid = 1'b0;
   logic [15:0] first_w = 16'h0000;
   logic [15:0] second_w = 16'h0000;
   logic [15:0] operand;
   logic [31:0] load_data;
   logic [7:0]  mem_addr;
   logic        crc_op;
   logic [31:0] store_data;
   logic        store_valid;
   logic [31:0] crc_result;
   logic        status_write;
   logic        dec;
   int          err_total = 0;
   int          checked = 0;

   always #5 mclk_i = ~mclk_i;

   bcrc_unit dut (.mclk_i(mclk_i), .reset_i(reset_i), .instr_valid_i(instr_valid),
      .first_opcode_word_i(first_w), .second_opcode_word_i(second_w),
      .half_word_memory_operand_i(operand), .load_data_i(load_data), .mem_addr_o(mem_addr),
      .crc_op_o(crc_op), .store_data_o(store_data), .store_valid_o(store_valid),
      .crc_result_register_o(crc_result), .status_write_o(status_write));

   bcrc_core_model core (.mclk_i(mclk_i), .mem_addr_i(mem_addr), .store_data_i(store_data),
      .store_valid_i(store_valid), .operand_o(operand), .load_data_o(load_data));

   // ==========================================================
   // Helpers
   function automatic logic [31:0] ref_fold(input logic [31:0] seed, input logic [7:0] d,
      input logic [31:0] poly, input int w);
      logic [31:0] c;
      logic [31:0] top;
      logic [31:0] mask;
      top  = 32'h1 << (w - 1);
      mask = (w == 32) ? 32'hffffffff : (top << 1) - 32'h1;
      c    = (seed & mask) ^ ({24'h0, d} << (w - 8));
      repeat (8) c = ((c & top) != 0) ? ((c << 1) ^ poly) : (c << 1);
      return c & mask;
   endfunction : ref_fold

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      checked++;
      if (got !== exp)
      begin
         err_total++;
         $display("wrong value at %0t: %s", $time, m);
      end
   endtask : chk

   // Called at a falling edge; returns one cycle later with the result settled
   task automatic op(input logic [15:0] f, input logic [15:0] s);
      instr_valid = 1'b1;
      first_w     = f;
      second_w    = s;
      #1 dec      = crc_op;
      @(negedge mclk_i);
      chk({31'h0, status_write}, 32'h0, "status written");
   endtask : op

   task automatic idle();
      instr_valid = 1'b0;
      @(negedge mclk_i);
   endtask : idle

   task automatic test_done();
      if (err_total == 0 && checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : test_done

   // ==========================================================
   // Scenarios
   task automatic t_crc(input logic [15:0] f, input logic [7:0] sel, input logic hi,
      input logic [31:0] poly, input int w);
      logic [31:0] exp;
      exp = ref_fold(32'h8badf00d, hi ? 8'ha5 : 8'h3c, poly, w);
      op(bcrc_pkg::OP_LOAD, 16'h0020);
      op(f, {sel, 8'h30});
      chk(crc_result, exp, "crc op result");
      chk({31'h0, dec}, 32'h1, "crc op not decoded");
      idle();
   endtask : t_crc

   task automatic t_chain();
      logic [31:0] exp;
      op(bcrc_pkg::OP_CLEAR, 16'h0000);
      op(bcrc_pkg::OP_CRC32_LO, 16'h0030);
      exp = ref_fold(32'h0, 8'h3c, bcrc_pkg::POLY32, 32);
      chk(crc_result, exp, "chain step 1");
      op(bcrc_pkg::OP_CRC32_HI, 16'h0030);
      exp = ref_fold(exp, 8'ha5, bcrc_pkg::POLY32, 32);
      chk(crc_result, exp, "chain step 2");
      op(bcrc_pkg::OP_CRC16B_HI, 16'h1030);
      exp = ref_fold(exp, 8'ha5, {16'h0, bcrc_pkg::POLY16B}, 16);
      chk(crc_result, exp, "chain step 3");
      idle();
   endtask : t_chain

   task automatic t_store();
      op(bcrc_pkg::OP_LOAD, 16'h0020);
      chk(crc_result, 32'h8badf00d, "load value");
      op(bcrc_pkg::OP_STORE, 16'h0040);
      chk({31'h0, store_valid}, 32'h1, "store pulse missing");
      chk(store_data, 32'h8badf00d, "store data");
      idle();
      chk({31'h0, store_valid}, 32'h0, "store pulse too long");
      chk({core.mem[8'h41], core.mem[8'h40]}, 32'h8badf00d, "stored word");
   endtask : t_store

   task automatic t_refused();
      op(bcrc_pkg::OP_LOAD, 16'h0020);
      op(16'he2ff, 16'h0030);
      chk({31'h0, dec}, 32'h0, "unknown op decoded");
      op(bcrc_pkg::OP_CRC16_LO, 16'h2030);
      chk({31'h0, dec}, 32'h0, "bad selector decoded");
      chk(crc_result, 32'h8badf00d, "refused op changed result");
      op(bcrc_pkg::OP_CLEAR, 16'h0000);
      chk(crc_result, 32'h0, "clear");
      idle();
   endtask : t_refused

   // Zero seed with a single 01 byte gives the polynomial; the other byte must not count
   task automatic t_known(input logic [15:0] hi_op, input logic [15:0] lo_op,
      input logic [7:0] sel, input logic [31:0] exp);
      op(bcrc_pkg::OP_CLEAR, 16'h0000);
      op(hi_op, {sel, 8'h51});
      chk(crc_result, 32'h0, "high op took low byte");
      op(hi_op, {sel, 8'h50});
      chk(crc_result, exp, "high op known answer");
      op(bcrc_pkg::OP_CLEAR, 16'h0000);
      op(lo_op, {sel, 8'h50});
      chk(crc_result, 32'h0, "low op took high byte");
      op(lo_op, {sel, 8'h51});
      chk(crc_result, exp, "low op known answer");
      idle();
   endtask : t_known

   initial
   begin
      repeat (10) @(negedge mclk_i);
      reset_i = 1'b0;
      chk(crc_result, 32'h0, "reset result");
      core.mem[8'h20] = 16'hf00d;
      core.mem[8'h21] = 16'h8bad;
      core.mem[8'h30] = 16'ha53c;
      t_crc(bcrc_pkg::OP_CRC8_HI, 8'h00, 1'b1, 32'h07, 8);
      t_crc(bcrc_pkg::OP_CRC8_LO, 8'h00, 1'b0, 32'h07, 8);
      t_crc(bcrc_pkg::OP_CRC16A_HI, 8'h00, 1'b1, 32'h8005, 16);
      t_crc(bcrc_pkg::OP_CRC16_LO, 8'h00, 1'b0, 32'h8005, 16);
      t_crc(bcrc_pkg::OP_CRC16B_HI, 8'h10, 1'b1, 32'h1021, 16);
      t_crc(bcrc_pkg::OP_CRC16_LO, 8'h10, 1'b0, 32'h1021, 16);
      t_crc(bcrc_pkg::OP_CRC32_HI, 8'h00, 1'b1, 32'h04c11db7, 32);
      t_crc(bcrc_pkg::OP_CRC32_LO, 8'h00, 1'b0, 32'h04c11db7, 32);
      t_chain();
      t_store();
      t_refused();
      core.mem[8'h50] = 16'h0100;
      core.mem[8'h51] = 16'h0001;
      t_known(bcrc_pkg::OP_CRC8_HI, bcrc_pkg::OP_CRC8_LO, 8'h00, 32'h00000007);
      t_known(bcrc_pkg::OP_CRC16A_HI, bcrc_pkg::OP_CRC16_LO, 8'h00, 32'h00008005);
      t_known(bcrc_pkg::OP_CRC16B_HI, bcrc_pkg::OP_CRC16_LO, 8'h10, 32'h00001021);
      t_known(bcrc_pkg::OP_CRC32_HI, bcrc_pkg::OP_CRC32_LO, 8'h00, 32'h04c11db7);
      test_done();
   end
endmodule : bcrc_unit_bench
